/* File: i2c_wiper_pkg.sv */
package i2c_wiper_pkg;

  // ==========================================================
  // Bus addresses of the two build variants and the general call
  // ==========================================================
  localparam logic [6:0] ADDR_VARIANT_A = 7'h2e;
  localparam logic [6:0] ADDR_VARIANT_B = 7'h3e;
  localparam logic [6:0] GENERAL_CALL = 7'h00;

  // ==========================================================
  // Frame layout
  // ==========================================================
  localparam int WIPER_BITS = 7;
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT_DONE = 3'h1;
  localparam int FRAME_BITS = 18;
  localparam logic [4:0] FRAME_LAST = 5'h11;
  localparam int ADDR_ACK_POS = 9;
  localparam logic [6:0] WIPER_RESET = 7'h00;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLOCK_KHZ = 20000;
  localparam int SCL_KHZ = 100;
  localparam int QUARTER_CYCLES = CLOCK_KHZ / (4 * SCL_KHZ);

  // ==========================================================
  // States
  // ==========================================================
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WRITE,
    ST_DATA_ACK,
    ST_READ,
    ST_READ_ACK,
    ST_IGNORE
  } target_state_type;

  typedef enum logic [1:0] {
    C_IDLE,
    C_START,
    C_BIT,
    C_STOP
  } controller_state_type;

endpackage

/* File: i2c_wiper_link_if.sv */
`timescale 1ns/1ps
interface i2c_wiper_link_if;
  logic scl;
  logic sda_ctl_oe;
  logic sda_dev_oe;
  wire sda;

  // Open-drain data line with pull-up
  assign sda = !(sda_ctl_oe || sda_dev_oe);

  modport controller (
    output scl,
    output sda_ctl_oe,
    input sda
  );

  modport target (
    input scl,
    input sda,
    output sda_dev_oe
  );
endinterface

/* File: i2c_controller_digital_potentiometer.sv */
`timescale 1ns/1ps
module i2c_controller_digital_potentiometer #(
  parameter logic [6:0] TARGET_ADDRESS = i2c_wiper_pkg::ADDR_VARIANT_A,
  parameter int QUARTER = i2c_wiper_pkg::QUARTER_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  i2c_wiper_link_if.controller link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_code,
  output logic done,
  output logic [7:0] read_code,
  output logic nack
);
  import i2c_wiper_pkg::*;

  localparam int TW = (QUARTER > 1) ? $clog2(QUARTER) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(QUARTER - 1);

  generate
    if (QUARTER < 4)
    begin : g_bad_quarter
      $error("QUARTER too small for synchronised sampling");
    end
  endgenerate

  // ==========================================================
  // Quarter-bit timebase
  // ==========================================================
  controller_state_type state;
  logic [TW-1:0] timer;
  logic [1:0] quarter;
  logic [4:0] bit_index;
  logic [FRAME_BITS-1:0] pattern;
  logic [FRAME_BITS-1:0] capture;
  logic read_op;
  logic scl;
  logic sda_oe;
  logic sda_meta;
  logic sda_sync;

  wire tick = (timer == TICK_LAST);
  wire start_cmd = (state == C_IDLE) && cmd_valid;
  wire [7:0] data_byte = cmd_read ? 8'hff : {1'b0, cmd_code};
  // Released slots carry 1; the final 1 is the read NACK
  wire [FRAME_BITS-1:0] next_pattern =
    {TARGET_ADDRESS, cmd_read, 1'b1, data_byte, 1'b1};

  assign cmd_ready = (state == C_IDLE);
  assign link.scl = scl;
  assign link.sda_ctl_oe = sda_oe;

  // ==========================================================
  // Data line synchroniser
  // ==========================================================
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end
    else
    begin
      sda_meta <= link.sda;
      sda_sync <= sda_meta;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      timer <= '0;
    else if (state == C_IDLE || tick)
      timer <= '0;
    else
      timer <= timer + 1'b1;
  end

  // ==========================================================
  // Frame sequencer
  // ==========================================================
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= C_IDLE;
      quarter <= 2'h0;
      bit_index <= 5'h00;
      pattern <= '1;
      capture <= '0;
      read_op <= 1'b0;
      scl <= 1'b1;
      sda_oe <= 1'b0;
      done <= 1'b0;
      read_code <= 8'h00;
      nack <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start_cmd)
      begin
        state <= C_START;
        quarter <= 2'h0;
        pattern <= next_pattern;
        read_op <= cmd_read;
      end
      else if (tick)
      begin
        quarter <= quarter + 2'h1;
        case (state)
          C_START:
          begin
            // RL4: falling data while clock high
            if (quarter == 2'h0)
              sda_oe <= 1'b1;
            if (quarter == 2'h1)
              scl <= 1'b0;
            if (quarter == 2'h3)
            begin
              state <= C_BIT;
              bit_index <= 5'h00;
            end
          end
          C_BIT:
          begin
            // RL11: data changes only while clock low
            if (quarter == 2'h0)
              sda_oe <= !pattern[FRAME_BITS-1];
            if (quarter == 2'h1)
              scl <= 1'b1;
            // RL10: one bit sampled per high phase
            if (quarter == 2'h2)
              capture <= {capture[FRAME_BITS-2:0], sda_sync};
            if (quarter == 2'h3)
            begin
              scl <= 1'b0;
              pattern <= {pattern[FRAME_BITS-2:0], 1'b1};
              bit_index <= bit_index + 5'h01;
              if (bit_index == FRAME_LAST)
                state <= C_STOP;
            end
          end
          C_STOP:
          begin
            // RL5: rising data while clock high
            if (quarter == 2'h0)
              sda_oe <= 1'b1;
            if (quarter == 2'h1)
              scl <= 1'b1;
            if (quarter == 2'h2)
              sda_oe <= 1'b0;
            // RL6: idle only after stop and bus free
            if (quarter == 2'h3)
            begin
              state <= C_IDLE;
              done <= 1'b1;
              read_code <= capture[BYTE_BITS:1];
              nack <= capture[ADDR_ACK_POS] | (!read_op & capture[0]);
            end
          end
          default:
            state <= C_IDLE;
        endcase
      end
    end
  end
endmodule // i2c_controller_digital_potentiometer

/* File: i2c_target_digital_potentiometer.sv */
// Contract
// RL1: Address MSB first, seven address bits, direction
// RL2: Never answer the general call
// RL3: Acknowledge matching address on ninth pulse
// RL4: Start condition begins address reception
// RL5: Stop condition returns to idle
// RL6: Controller starts only on idle bus
// RL7: Write data byte follows address acknowledge
// RL8: Acknowledge every received data byte
// RL9: Update wiper only from complete bytes
// RL10: One bit per clock, sampled high
// RL11: Data change while clock high is control
// RL12: Unlimited data bytes per transaction
// RL13: Eight bits plus one acknowledge bit
// RL14: Transmitter releases line after eighth bit
// RL15: Acknowledge low across whole high phase
// RL16: Code selects one of 128 linear taps
// RL17: Wiper set only through serial interface
// RL18: Read returns current code MSB first
// RL19: Store low seven bits only
// RL20: Mismatched address ignored until next start
`timescale 1ns/1ps
module i2c_target_digital_potentiometer #(
  parameter logic [6:0] OWN_ADDRESS = i2c_wiper_pkg::ADDR_VARIANT_A
) (
  input wire logic clock,
  input wire logic rst_n,
  i2c_wiper_link_if.target link,
  output logic [6:0] wiper_code,
  output logic wiper_update
);
  import i2c_wiper_pkg::*;

  generate
    // RL2: general call can never match
    if (OWN_ADDRESS == GENERAL_CALL)
    begin : g_bad_address
      $error("OWN_ADDRESS must not be the general call address");
    end
  endgenerate

  // ==========================================================
  // Start and stop detection
  // ==========================================================
  // Toggles, so the bit engine needs no async clear
  logic start_toggle;
  logic stop_toggle;

  // RL4: falling data while clock high
  always_ff @(negedge link.sda or negedge rst_n)
  begin
    if (!rst_n)
      start_toggle <= 1'b0;
    else if (link.scl)
      start_toggle <= ~start_toggle;
  end

  // RL5: rising data while clock high
  always_ff @(posedge link.sda or negedge rst_n)
  begin
    if (!rst_n)
      stop_toggle <= 1'b0;
    else if (link.scl)
      stop_toggle <= ~stop_toggle;
  end

  // ==========================================================
  // Bit engine on the link clock
  // ==========================================================
  target_state_type state;
  target_state_type next_state;
  logic start_seen;
  logic stop_seen;
  logic [2:0] count;
  logic [2:0] next_count;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic [6:0] code;
  logic [6:0] next_code;
  logic rw;
  logic next_rw;
  logic commit_toggle;
  logic next_commit_toggle;
  logic drive;

  wire start_pending = (start_toggle != start_seen);
  wire stop_pending = (stop_toggle != stop_seen);
  // RL1: MSB first into the low end
  wire [7:0] shifted = {shift[6:0], link.sda};
  wire addr_match = (shifted[7:1] == OWN_ADDRESS);
  wire byte_end = (count == LAST_BIT);
  wire [7:0] read_byte = {1'b0, code};

  always_comb
  begin
    next_state = state;
    next_count = count;
    next_shift = shift;
    next_tx = tx;
    next_code = code;
    next_rw = rw;
    next_commit_toggle = commit_toggle;
    if (start_pending)
    begin
      // RL9: partial byte from an aborted frame is dropped
      next_state = ST_ADDR;
      next_count = FIRST_BIT_DONE;
      next_shift = {7'h00, link.sda};
    end
    else if (stop_pending)
    begin
      // RL5: stop leaves the engine idle
      next_state = ST_IDLE;
    end
    else
    begin
      case (state)
        ST_ADDR:
        begin
          // RL10: one bit on each rising clock
          next_shift = shifted;
          next_count = count + 3'h1;
          if (byte_end)
          begin
            next_rw = shifted[0];
            // RL2: only the own address is answered
            // RL20: a mismatch waits for the next start
            next_state = addr_match ? ST_ADDR_ACK : ST_IGNORE;
          end
        end
        ST_ADDR_ACK:
        begin
          // RL7: data byte follows the acknowledge
          next_count = 3'h0;
          next_tx = read_byte;
          next_state = rw ? ST_READ : ST_WRITE;
        end
        ST_WRITE:
        begin
          next_shift = shifted;
          next_count = count + 3'h1;
          // RL13: eighth bit leads to acknowledge slot
          if (byte_end)
            next_state = ST_DATA_ACK;
        end
        ST_DATA_ACK:
        begin
          // RL9: commit on the rising edge of the acknowledge pulse
          // RL19: top bit of the byte is dropped
          next_code = shift[WIPER_BITS-1:0];
          next_commit_toggle = ~commit_toggle;
          next_count = 3'h0;
          // RL12: any number of further bytes
          next_state = ST_WRITE;
        end
        ST_READ:
        begin
          // RL18: shift out current code
          next_tx = {tx[6:0], 1'b0};
          next_count = count + 3'h1;
          if (byte_end)
            next_state = ST_READ_ACK;
        end
        ST_READ_ACK:
        begin
          // Controller acknowledge asks for another byte
          next_count = 3'h0;
          next_tx = read_byte;
          next_state = link.sda ? ST_IGNORE : ST_READ;
        end
        ST_IDLE, ST_IGNORE:
          next_state = state;
        default:
          next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge link.scl or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
      count <= 3'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      code <= WIPER_RESET;
      rw <= 1'b0;
      commit_toggle <= 1'b0;
    end
    else
    begin
      state <= next_state;
      start_seen <= start_toggle;
      stop_seen <= stop_toggle;
      count <= next_count;
      shift <= next_shift;
      tx <= next_tx;
      code <= next_code;
      rw <= next_rw;
      commit_toggle <= next_commit_toggle;
    end
  end

  // ==========================================================
  // Data line drive on the falling clock
  // ==========================================================
  // Falling-edge drive never mimics a start or stop
  wire ack_slot = (state == ST_ADDR_ACK) || (state == ST_DATA_ACK);
  wire read_low = (state == ST_READ) && !tx[7];
  // RL3: address acknowledge on ninth pulse
  // RL8: data acknowledge; RL15: low for whole high phase
  // RL14: released after our eighth read bit
  wire next_drive = ack_slot || read_low;

  // RL11: output changes only while clock is low
  always_ff @(negedge link.scl or negedge rst_n)
  begin
    if (!rst_n)
      drive <= 1'b0;
    else
      drive <= next_drive;
  end

  assign link.sda_dev_oe = drive;

  // ==========================================================
  // Wiper hand-over to the core clock
  // ==========================================================
  // Code word holds a byte time, far beyond sync latency
  logic commit_meta;
  logic commit_sync;
  logic commit_done;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      commit_meta <= 1'b0;
      commit_sync <= 1'b0;
      commit_done <= 1'b0;
    end
    else
    begin
      commit_meta <= commit_toggle;
      commit_sync <= commit_meta;
      commit_done <= commit_sync;
    end
  end

  wire commit_edge = (commit_sync != commit_done);

  // RL16: code is the linear tap number
  // RL17: only the serial path changes the wiper
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wiper_code <= WIPER_RESET;
      wiper_update <= 1'b0;
    end
    else
    begin
      wiper_update <= commit_edge;
      if (commit_edge)
        wiper_code <= code;
    end
  end
endmodule // i2c_target_digital_potentiometer

/* File: i2c_wiper_link_checker.sv */
`timescale 1ns/1ps
module i2c_wiper_link_checker #(
  parameter logic [6:0] OWN_ADDRESS = i2c_wiper_pkg::ADDR_VARIANT_A,
  parameter int QUARTER = i2c_wiper_pkg::QUARTER_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_ctl_oe,
  input wire logic sda_dev_oe,
  input wire logic sda
);
  // ========
  // Bus event tracking
  logic scl_q;
  logic sda_q;
  logic [4:0] pulses;
  logic [7:0] addr_byte;
  wire logic rise = scl && !scl_q;
  wire logic start_seen = scl && scl_q && sda_q && !sda;
  wire logic stop_seen = scl && scl_q && !sda_q && sda;
  wire logic match = addr_byte[7:1] == OWN_ADDRESS;
  wire logic shift_en = rise && (pulses < 5'h08);
  wire logic [4:0] next_pulses = start_seen ? 5'h00 : pulses + 5'(rise);
  wire logic [7:0] next_addr_byte =
    shift_en ? {addr_byte[6:0], sda} : addr_byte;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      pulses <= 5'h00;
      addr_byte <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      pulses <= next_pulses;
      addr_byte <= next_addr_byte;
    end
  end

  // ========
  // Properties
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_start;
    start_seen;
  endsequence
  sequence s_stop;
    stop_seen;
  endsequence
  sequence s_ninth;
    rise && pulses == 5'h08;
  endsequence
  sequence s_data_slot;
    rise && pulses == 5'h11;
  endsequence

  property p_dev_edge;
    $changed(sda_dev_oe) |-> !scl;
  endproperty
  property p_setup;
    $changed(scl) |-> $stable(sda_ctl_oe);
  endproperty
  property p_start;
    s_start |-> scl [*3] ##[1:QUARTER] !scl;
  endproperty
  property p_stop;
    s_stop |-> (sda && !sda_dev_oe) [*4];
  endproperty
  property p_frame;
    s_stop |-> pulses == 5'h13;
  endproperty
  property p_addr_quiet;
    shift_en |-> !sda_dev_oe;
  endproperty
  property p_release;
    rise && (pulses == 5'h08 || pulses == 5'h11) |-> !sda_ctl_oe;
  endproperty
  property p_addr_ack;
    s_ninth ##0 match |-> sda_dev_oe;
  endproperty
  property p_data_ack;
    s_data_slot ##0 (match && !addr_byte[0]) |-> sda_dev_oe;
  endproperty

  a_dev_edge:
    assert property (p_dev_edge) else $error("target data moved in high");
  a_setup:
    assert property (p_setup) else $error("data moved with clock edge");
  a_start:
    assert property (p_start) else $error("start shape wrong");
  a_stop:
    assert property (p_stop) else $error("bus not idle after stop");
  a_frame:
    assert property (p_frame) else $error("frame pulse count wrong");
  a_addr_quiet:
    assert property (p_addr_quiet) else $error("target drove address");
  a_release:
    assert property (p_release) else $error("controller held ack slot");
  a_addr_ack:
    assert property (p_addr_ack) else $error("address not acked");
  a_data_ack:
    assert property (p_data_ack) else $error("data byte not acked");
endmodule // i2c_wiper_link_checker

/* File: testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end
module testbench;
  import i2c_wiper_pkg::*;
  localparam int Q = 4;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [6:0] cmd_code = 7'h00;
  logic cmd_ready, done, nack, wiper_update, wiper_update2, got, ack;
  logic [7:0] read_code, rx, d;
  logic [6:0] wiper_code, wiper_code2, model, c;
  logic [6:0] foreign [2] = '{GENERAL_CALL, ADDR_VARIANT_A};
  logic [31:0] seed = 32'h7ca8;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;
  int upd = 0;
  int upd2 = 0;

  i2c_wiper_link_if link();
  i2c_wiper_link_if link2();
  i2c_controller_digital_potentiometer #(.QUARTER(Q))
    i2c_controller_digital_potentiometer_inst (.clock(clock),
    .rst_n(rst_n), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_code(cmd_code),
    .done(done), .read_code(read_code), .nack(nack));
  i2c_target_digital_potentiometer i2c_target_digital_potentiometer_inst (
    .clock(clock), .rst_n(rst_n), .link(link),
    .wiper_code(wiper_code), .wiper_update(wiper_update));
  // Second link: bench plays a free-running controller
  i2c_target_digital_potentiometer #(.OWN_ADDRESS(ADDR_VARIANT_B))
    i2c_target_digital_potentiometer_inst2 (.clock(clock), .rst_n(rst_n),
    .link(link2), .wiper_code(wiper_code2), .wiper_update(wiper_update2));
  i2c_wiper_link_checker #(.OWN_ADDRESS(ADDR_VARIANT_A), .QUARTER(Q))
    i2c_wiper_link_checker_inst (.clock(clock), .rst_n(rst_n),
    .scl(link.scl), .sda_ctl_oe(link.sda_ctl_oe),
    .sda_dev_oe(link.sda_dev_oe), .sda(link.sda));

  // ========
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [6:0] code_of(input logic [7:0] b);
    return b[6:0];
  endfunction

  task automatic test_done;
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic xfer(input logic rd, input logic [6:0] code);
    int n;
    int u;
    u = upd;
    @(negedge clock);
    `CHK("ready", 1'b1, cmd_ready)
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_code = code;
    @(negedge clock);
    cmd_valid = 1'b0;
    `CHK("busy", 1'b0, cmd_ready)
    for (n = 0; n < 400 && done !== 1'b1; n++)
      @(negedge clock);
    `CHK("done", 1'b1, done)
    `CHK("nack", 1'b0, nack)
    if (!rd)
      model = code;
    `CHK("wiper", model, wiper_code)
    `CHK("updates", u + (rd ? 0 : 1), upd)
    if (rd)
      `CHK("readback", {1'b0, model}, read_code)
  endtask

  task automatic qw;
    repeat (Q) @(negedge clock);
  endtask
  task automatic bb_bit(input logic b);
    link2.sda_ctl_oe = !b;
    qw();
    link2.scl = 1'b1;
    qw();
    got = link2.sda;
    qw();
    link2.scl = 1'b0;
    qw();
  endtask
  task automatic bb_start;
    link2.sda_ctl_oe = 1'b0;
    qw();
    link2.scl = 1'b1;
    qw();
    link2.sda_ctl_oe = 1'b1;
    qw();
    link2.scl = 1'b0;
    qw();
  endtask
  task automatic bb_stop;
    link2.sda_ctl_oe = 1'b1;
    qw();
    link2.scl = 1'b1;
    qw();
    link2.sda_ctl_oe = 1'b0;
    qw();
  endtask
  // Sending all ones reads the target's byte
  task automatic bb_byte(input logic [7:0] v, output logic a,
                         output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      bb_bit(v[i]);
      r[i] = got;
    end
    bb_bit(1'b1);
    a = !got;
  endtask

  // ========
  // Clock, watchdog, main sequence
  initial
  begin
    forever #25 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (wiper_update === 1'b1)
      upd++;
    if (wiper_update2 === 1'b1)
      upd2++;
    if (cycles == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end

  initial
  begin
    link2.scl = 1'b1;
    link2.sda_ctl_oe = 1'b0;
    model = 7'h00;
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      c = (k == 0) ? 7'h7f : (k == 1) ? 7'h00 : seed[6:0];
      seed = lfsr(seed);
      xfer(1'b0, c);
      xfer(1'b1, 7'h00);
    end
    foreach (foreign[k])
    begin
      bb_start();
      bb_byte({foreign[k], 1'b0}, ack, rx);
      `CHK("foreign ack", 1'b0, ack)
      bb_byte(8'h55, ack, rx);
      `CHK("ignored data", 1'b0, ack)
      bb_stop();
    end
    `CHK("ignored code", 7'h00, wiper_code2)
    bb_start();
    bb_byte({ADDR_VARIANT_B, 1'b0}, ack, rx);
    `CHK("own ack", 1'b1, ack)
    for (int k = 0; k < 3; k++)
    begin
      d = seed[7:0] | 8'h80;
      seed = lfsr(seed);
      bb_byte(d, ack, rx);
      `CHK("data ack", 1'b1, ack)
      `CHK("low seven", code_of(d), wiper_code2)
    end
    bb_stop();
    bb_start();
    bb_byte({ADDR_VARIANT_B, 1'b0}, ack, rx);
    repeat (5) bb_bit(1'b0);
    bb_start();
    bb_byte({ADDR_VARIANT_B, 1'b0}, ack, rx);
    repeat (3) bb_bit(1'b0);
    bb_stop();
    `CHK("partial", code_of(d), wiper_code2)
    bb_start();
    bb_byte({ADDR_VARIANT_B, 1'b0}, ack, rx);
    bb_byte(8'h2a, ack, rx);
    bb_start();
    bb_byte({ADDR_VARIANT_B, 1'b1}, ack, rx);
    `CHK("read ack", 1'b1, ack)
    // Controller acknowledge asks for a second byte
    for (int i = 7; i >= 0; i--)
    begin
      bb_bit(1'b1);
      d[i] = got;
    end
    bb_bit(1'b0);
    bb_byte(8'hff, ack, rx);
    bb_stop();
    `CHK("read byte", 8'h2a, d)
    `CHK("read again", 8'h2a, rx)
    `CHK("updates2", 4, upd2)
    test_done();
  end
endmodule // testbench
